// ---- hdl/tcc_cfg.svh ----
// register indices, field positions, reset values and counts of the timer
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// register indices; byte address is four times the index
`define TCC_IDX_WAVE_CTRL 8'h80
`define TCC_IDX_CAP_CLK_CTRL 8'h81
`define TCC_IDX_FORCE_CTRL 8'h82
`define TCC_IDX_CNT_LO 8'h84
`define TCC_IDX_CNT_HI 8'h85
`define TCC_IDX_CAP_LO 8'h86
`define TCC_IDX_CAP_HI 8'h87
`define TCC_IDX_CMPA_LO 8'h88
`define TCC_IDX_CMPA_HI 8'h89
`define TCC_IDX_CMPB_LO 8'h8a
`define TCC_IDX_CMPB_HI 8'h8b
`define TCC_IDX_IRQ_MASK 8'h8c
`define TCC_IDX_IRQ_FLAGS 8'h8d
`define TCC_IDX_AUX_CTRL 8'h8e

// capture_and_clock_control fields
`define TCC_CCC_FILTER_BIT 7
`define TCC_CCC_EDGE_BIT 6
`define TCC_CCC_WGM_HI_LSB 3
`define TCC_CCC_CS_LSB 0
// waveform_control fields
`define TCC_WC_COMA_LSB 6
`define TCC_WC_COMB_LSB 4
`define TCC_WC_WGM_LO_LSB 0
// force_compare_control strobes
`define TCC_FORCE_A_BIT 7
`define TCC_FORCE_B_BIT 6
// interrupt mask and flag positions
`define TCC_IRQ_CAP_BIT 5
`define TCC_IRQ_CMPB_BIT 2
`define TCC_IRQ_CMPA_BIT 1
`define TCC_IRQ_OVF_BIT 0
// aux control: capture source select
`define TCC_AUX_CMP_SRC_BIT 0

// reset values and counts
`define TCC_RST_BYTE 8'h00
`define TCC_RST_WORD 16'h0000
`define TCC_MAX_COUNT 16'hffff
`define TCC_FILTER_SAMPLES 4

`endif

// ---- hdl/tcc_pkg.sv ----
// types shared by the timer design
package tcc_pkg;

  // one bit per interrupt source
  typedef struct packed {
    logic capture;
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } tcc_irq_s;

  // latched address phase of a bus transfer
  typedef struct packed {
    logic [7:0] index;
    logic write;
  } tcc_addr_phase_s;

  // bus slave phase
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ
  } tcc_phase_e;

endpackage

// ---- hdl/tcc_timer16.sv ----
// 16-bit timer with capture, force compare, byte access and irq flags
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"

module tcc_timer16
  import tcc_pkg::*;
#(
  parameter int FILTER_SAMPLES = `TCC_FILTER_SAMPLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic capture_pin,
  input wire logic comparator_out,
  input wire logic external_clock_pin,
  input wire logic global_irq_enable,
  input wire tcc_irq_s vector_ack,
  output tcc_irq_s irq_request,
  output logic waveform_out_a,
  output logic waveform_out_b,
  output logic waveform_oe_a,
  output logic waveform_oe_b
);

  // the filter window must hold at least two samples
  if (FILTER_SAMPLES < 2 || FILTER_SAMPLES > 16) begin : g_chk
    $error("FILTER_SAMPLES must lie in 2..16");
  end

  // mode decoding from the 4-bit waveform mode
  function automatic logic mode_phase(input logic [3:0] m);
    return m inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11};
  endfunction

  function automatic logic mode_fast(input logic [3:0] m);
    return m inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15};
  endfunction

  function automatic logic mode_cap_top(input logic [3:0] m);
    return m inside {4'd8, 4'd10, 4'd12, 4'd14};
  endfunction

  function automatic logic [15:0] mode_top(input logic [3:0] m,
                                           input logic [15:0] cmpa,
                                           input logic [15:0] cap);
    case (m)
      4'd1, 4'd5: return 16'h00ff;
      4'd2, 4'd6: return 16'h01ff;
      4'd3, 4'd7: return 16'h03ff;
      4'd4, 4'd9, 4'd11, 4'd15: return cmpa;
      4'd8, 4'd10, 4'd12, 4'd14: return cap;
      default: return `TCC_MAX_COUNT;
    endcase
  endfunction

  // compare output action: toggle, clear or set; inv swaps clear and set
  function automatic logic wave_act(input logic cur, input logic [1:0] com,
                                    input logic inv);
    case (com)
      2'd1: return ~cur;
      2'd2: return inv;
      2'd3: return ~inv;
      default: return cur;
    endcase
  endfunction

  // next waveform level for one channel
  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input logic [3:0] m, input logic down,
                                     input logic match, input logic force_s,
                                     input logic top_ev);
    logic r;
    r = cur;
    if (!mode_phase(m) && !mode_fast(m)) begin
      if (match || force_s) begin
        r = wave_act(cur, com, 1'b0);
      end
    end else if (com[1]) begin
      if (match) begin
        r = wave_act(cur, com, down);
      end
      if (mode_fast(m) && top_ev) begin
        r = wave_act(cur, com, 1'b1);
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] irq_to_byte(input tcc_irq_s s);
    logic [7:0] b;
    b = `TCC_RST_BYTE;
    b[`TCC_IRQ_CAP_BIT] = s.capture;
    b[`TCC_IRQ_CMPB_BIT] = s.cmp_b;
    b[`TCC_IRQ_CMPA_BIT] = s.cmp_a;
    b[`TCC_IRQ_OVF_BIT] = s.ovf;
    return b;
  endfunction

  function automatic tcc_irq_s byte_to_irq(input logic [7:0] b);
    tcc_irq_s s;
    s.capture = b[`TCC_IRQ_CAP_BIT];
    s.cmp_b = b[`TCC_IRQ_CMPB_BIT];
    s.cmp_a = b[`TCC_IRQ_CMPA_BIT];
    s.ovf = b[`TCC_IRQ_OVF_BIT];
    return s;
  endfunction

  tcc_phase_e phase_reg;
  tcc_addr_phase_s addr_reg;
  logic hreadyout_reg, hresp_reg;
  logic [31:0] hrdata_reg;
  logic [7:0] wave_ctrl_reg, ccc_reg, mask_byte, rd_byte, wr_byte;
  logic aux_cmp_src_reg, temp_wr;
  logic [7:0] temp_reg, temp_next;
  logic [15:0] cnt_reg, cnt_next, cap_reg, cmpa_reg, cmpb_reg, top;
  logic dir_reg, dir_next, block_reg, ovf_hit;
  logic [9:0] pre_reg;
  logic [3:0] mode;
  logic accept, wr_en, rd_en, tick, at_top;
  logic cap_s1, cap_s2, cmp_s1, cmp_s2, ext_s1, ext_s2, ext_prev;
  logic cap_src, filt_reg, cap_lvl, cap_prev, cap_edge, capture_evt;
  logic [FILTER_SAMPLES-2:0] samp_reg;
  logic [FILTER_SAMPLES-1:0] window;
  logic match_a, match_b, top_ev, force_a, force_b, pwm;
  tcc_irq_s flags_reg, mask_reg, flag_set, flag_clr, irq_reg;
  logic wave_a_reg, wave_b_reg, oe_a_reg, oe_b_reg;

  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign irq_request = irq_reg;
  assign waveform_out_a = wave_a_reg;
  assign waveform_out_b = wave_b_reg;
  assign waveform_oe_a = oe_a_reg;
  assign waveform_oe_b = oe_b_reg;

  // bus decode; only the low data byte carries register content
  assign accept = hsel && hready && htrans[1];
  assign wr_en = phase_reg == PH_WRITE;
  assign rd_en = phase_reg == PH_READ;
  assign wr_byte = hwdata[7:0];
  assign mode = {ccc_reg[`TCC_CCC_WGM_HI_LSB +: 2],
                 wave_ctrl_reg[`TCC_WC_WGM_LO_LSB +: 2]};
  assign pwm = mode_phase(mode) || mode_fast(mode);
  assign mask_byte = irq_to_byte(mask_reg);

  // ahb slave: writes zero-wait, reads one wait so hrdata is registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= PH_IDLE;
      addr_reg <= '0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
      hresp_reg <= 1'b0;
    end else if (clk_en) begin
      case (phase_reg)
        PH_READ: begin
          hrdata_reg <= 32'(rd_byte);
          hreadyout_reg <= 1'b1;
          phase_reg <= PH_IDLE;
        end
        default: begin
          if (accept) begin
            addr_reg.index <= haddr[9:2];
            addr_reg.write <= hwrite;
            phase_reg <= hwrite ? PH_WRITE : PH_READ;
            hreadyout_reg <= hwrite;
          end else begin
            phase_reg <= PH_IDLE;
          end
        end
      endcase
    end
  end

  // read mux; reserved bits and strobes read zero, unmapped reads zero
  always_comb begin
    case (addr_reg.index)
      `TCC_IDX_WAVE_CTRL: rd_byte = wave_ctrl_reg & 8'hf3;
      `TCC_IDX_CAP_CLK_CTRL: rd_byte = ccc_reg & 8'hdf;
      `TCC_IDX_CNT_LO: rd_byte = cnt_reg[7:0];
      `TCC_IDX_CAP_LO: rd_byte = cap_reg[7:0];
      `TCC_IDX_CMPA_LO: rd_byte = cmpa_reg[7:0];
      `TCC_IDX_CMPB_LO: rd_byte = cmpb_reg[7:0];
      `TCC_IDX_CNT_HI, `TCC_IDX_CAP_HI,
      `TCC_IDX_CMPA_HI, `TCC_IDX_CMPB_HI: rd_byte = temp_reg;
      `TCC_IDX_IRQ_MASK: rd_byte = mask_byte;
      `TCC_IDX_IRQ_FLAGS: rd_byte = irq_to_byte(flags_reg);
      `TCC_IDX_AUX_CTRL: rd_byte = {7'h00, aux_cmp_src_reg};
      default: rd_byte = `TCC_RST_BYTE; // force register too
    endcase
  end

  // shared temp byte: high write loads it, low read latches high half
  always_comb begin
    temp_wr = 1'b1;
    temp_next = temp_reg;
    case (addr_reg.index)
      `TCC_IDX_CNT_HI, `TCC_IDX_CAP_HI,
      `TCC_IDX_CMPA_HI, `TCC_IDX_CMPB_HI: temp_next = wr_byte;
      `TCC_IDX_CNT_LO: temp_next = cnt_reg[15:8];
      `TCC_IDX_CAP_LO: temp_next = cap_reg[15:8];
      `TCC_IDX_CMPA_LO: temp_next = cmpa_reg[15:8];
      `TCC_IDX_CMPB_LO: temp_next = cmpb_reg[15:8];
      default: temp_wr = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_reg <= `TCC_RST_BYTE;
    end else if (clk_en && temp_wr) begin
      // high write or low read touches temp, never the other way round
      if ((wr_en && addr_reg.index[0]) || (rd_en && !addr_reg.index[0])) begin
        temp_reg <= temp_next;
      end
    end
  end

  // control registers; reserved bits kept zero whatever is written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_ctrl_reg <= `TCC_RST_BYTE;
      ccc_reg <= `TCC_RST_BYTE;
      mask_reg <= '0;
      aux_cmp_src_reg <= 1'b0;
      cmpa_reg <= `TCC_RST_WORD;
      cmpb_reg <= `TCC_RST_WORD;
    end else if (clk_en && wr_en) begin
      case (addr_reg.index)
        `TCC_IDX_WAVE_CTRL: wave_ctrl_reg <= wr_byte & 8'hf3;
        `TCC_IDX_CAP_CLK_CTRL: ccc_reg <= wr_byte & 8'hdf;
        `TCC_IDX_IRQ_MASK: mask_reg <= byte_to_irq(wr_byte);
        `TCC_IDX_AUX_CTRL: aux_cmp_src_reg <= wr_byte[`TCC_AUX_CMP_SRC_BIT];
        `TCC_IDX_CMPA_LO: cmpa_reg <= {temp_reg, wr_byte};
        `TCC_IDX_CMPB_LO: cmpb_reg <= {temp_reg, wr_byte};
        default: ;
      endcase
    end
  end

  // pin synchronisers and free-running prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cap_s1, cap_s2, cmp_s1, cmp_s2} <= 4'h0;
      {ext_s1, ext_s2, ext_prev} <= 3'h0;
      pre_reg <= 10'h000;
    end else if (clk_en) begin
      cap_s1 <= capture_pin;
      cap_s2 <= cap_s1;
      cmp_s1 <= comparator_out;
      cmp_s2 <= cmp_s1;
      ext_s1 <= external_clock_pin;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
      pre_reg <= pre_reg + 10'h001;
    end
  end

  // clock select decode
  always_comb begin
    case (ccc_reg[`TCC_CCC_CS_LSB +: 3])
      3'd1: tick = 1'b1;
      3'd2: tick = &pre_reg[2:0];
      3'd3: tick = &pre_reg[5:0];
      3'd4: tick = &pre_reg[7:0];
      3'd5: tick = &pre_reg[9:0];
      3'd6: tick = ext_prev & ~ext_s2;
      3'd7: tick = ~ext_prev & ext_s2;
      default: tick = 1'b0;
    endcase
  end

  // capture source, majority-free noise filter and edge detector
  assign cap_src = aux_cmp_src_reg ? cmp_s2 : cap_s2;
  assign window = {samp_reg, cap_src};
  assign cap_lvl = ccc_reg[`TCC_CCC_FILTER_BIT] ? filt_reg : cap_src;
  assign cap_edge = ccc_reg[`TCC_CCC_EDGE_BIT] ? (cap_lvl & ~cap_prev)
                                               : (~cap_lvl & cap_prev);
  assign capture_evt = cap_edge && !mode_cap_top(mode);

  // filter runs always so enabling it cannot fake an edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_reg <= '0;
      filt_reg <= 1'b0;
      cap_prev <= 1'b0;
    end else if (clk_en) begin
      samp_reg <= window[FILTER_SAMPLES-2:0];
      if (&window) begin
        filt_reg <= 1'b1;
      end else if (~|window) begin
        filt_reg <= 1'b0;
      end
      cap_prev <= cap_lvl;
    end
  end

  // counter sequencing per waveform mode
  assign top = mode_top(mode, cmpa_reg, cap_reg);
  assign at_top = cnt_reg == top;
  always_comb begin
    cnt_next = cnt_reg + 16'h0001;
    dir_next = dir_reg;
    ovf_hit = 1'b0;
    if (mode_phase(mode)) begin
      if (dir_reg && cnt_reg == `TCC_RST_WORD) begin
        dir_next = 1'b0;
        ovf_hit = 1'b1;
      end else if (dir_reg || at_top) begin
        dir_next = 1'b1;
        cnt_next = cnt_reg - 16'h0001;
      end
    end else if (mode_fast(mode)) begin
      if (at_top) begin
        cnt_next = `TCC_RST_WORD;
        ovf_hit = 1'b1;
      end
    end else begin
      if (at_top) begin
        cnt_next = `TCC_RST_WORD;
      end
      ovf_hit = cnt_reg == `TCC_MAX_COUNT;
    end
  end

  // counter, direction and compare blocking after a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= `TCC_RST_WORD;
      dir_reg <= 1'b0;
      block_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_en && addr_reg.index == `TCC_IDX_CNT_LO) begin
        cnt_reg <= {temp_reg, wr_byte};
        block_reg <= 1'b1;
      end else if (tick) begin
        cnt_reg <= cnt_next;
        dir_reg <= dir_next;
        block_reg <= 1'b0;
      end
    end
  end

  // capture register: hardware event wins over a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_reg <= `TCC_RST_WORD;
    end else if (clk_en) begin
      if (capture_evt) begin
        cap_reg <= cnt_reg;
      end else if (wr_en && addr_reg.index == `TCC_IDX_CAP_LO) begin
        cap_reg <= {temp_reg, wr_byte};
      end
    end
  end

  // compare matches and force strobes
  assign match_a = tick && !block_reg && cnt_reg == cmpa_reg;
  assign match_b = tick && !block_reg && cnt_reg == cmpb_reg;
  assign top_ev = tick && at_top;
  assign force_a = wr_en && addr_reg.index == `TCC_IDX_FORCE_CTRL &&
                   wr_byte[`TCC_FORCE_A_BIT] && !pwm;
  assign force_b = wr_en && addr_reg.index == `TCC_IDX_FORCE_CTRL &&
                   wr_byte[`TCC_FORCE_B_BIT] && !pwm;

  // waveform pins; a disconnected mode drops the output enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_a_reg <= 1'b0;
      wave_b_reg <= 1'b0;
      oe_a_reg <= 1'b0;
      oe_b_reg <= 1'b0;
    end else if (clk_en) begin
      wave_a_reg <= wave_next(wave_a_reg,
                              wave_ctrl_reg[`TCC_WC_COMA_LSB +: 2], mode,
                              dir_reg, match_a, force_a, top_ev);
      wave_b_reg <= wave_next(wave_b_reg,
                              wave_ctrl_reg[`TCC_WC_COMB_LSB +: 2], mode,
                              dir_reg, match_b, force_b, top_ev);
      oe_a_reg <= |wave_ctrl_reg[`TCC_WC_COMA_LSB +: 2];
      oe_b_reg <= |wave_ctrl_reg[`TCC_WC_COMB_LSB +: 2];
    end
  end

  // flag sources; strobes feed none of them
  always_comb begin
    flag_set.capture = mode_cap_top(mode) ? top_ev : capture_evt;
    flag_set.cmp_b = match_b;
    flag_set.cmp_a = match_a;
    flag_set.ovf = tick && ovf_hit;
    flag_clr = vector_ack;
    if (wr_en && addr_reg.index == `TCC_IDX_IRQ_FLAGS) begin
      flag_clr = vector_ack | byte_to_irq(wr_byte);
    end
  end

  // sticky flags, set wins over clear, and gated requests
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= '0;
      irq_reg <= '0;
    end else if (clk_en) begin
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
      irq_reg <= flags_reg & mask_reg & {4{global_irq_enable}};
    end
  end

endmodule
`default_nettype wire

// ---- tb/tcc_pin_model.sv ----
// pin-side partner: drives the capture, comparator and external clock pins
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  input wire logic hclk,
  output logic capture_pin,
  output logic comparator_out,
  output logic external_clock_pin
);
  // pins idle low until a scenario moves them
  initial begin
    capture_pin = 1'b0;
    comparator_out = 1'b0;
    external_clock_pin = 1'b0;
  end
  // set one pin (0 capture, 1 comparator, 2 clock), hold n+1 cycles
  task automatic drive(input int k, input logic v, input int n);
    @(posedge hclk);
    if (k == 0) begin
      capture_pin <= v;
    end else if (k == 1) begin
      comparator_out <= v;
    end else begin
      external_clock_pin <= v;
    end
    repeat (n) @(posedge hclk);
  endtask
  // halves of four cycles, well above the sampling limit
  task automatic pulses(input int n);
    repeat (n) begin
      drive(2, 1'b1, 3);
      drive(2, 1'b0, 3);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/tcc_timer16_assertions.sv ----
// bus timing and read-side checks on the timer top-level ports
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"
module tcc_timer16_chk
  import tcc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic global_irq_enable,
  input wire tcc_irq_s irq_request
);
  logic [7:0] rd_idx;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // index of the read in flight, so its returned data can be judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_idx <= 8'h00;
    end else if (hsel && hready && htrans[1] && !hwrite && clk_en) begin
      rd_idx <= haddr[9:2];
    end
  end
  // address phases taken, and the single wait of a read
  sequence rd_take;
    hsel && hready && htrans[1] && !hwrite && clk_en;
  endsequence
  sequence wr_take;
    hsel && hready && htrans[1] && hwrite && clk_en;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (rd_take |=> one_wait)
    else $error("read did not wait exactly one cycle");
  a_write_nowait: assert property (wr_take |=> hreadyout)
    else $error("write inserted a wait state");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_rdata_holds: assert property (
    !$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_force_zero: assert property (
    $rose(hreadyout) && rd_idx == `TCC_IDX_FORCE_CTRL
    |-> hrdata[7:0] == 8'h00)
    else $error("force strobes read back nonzero");
  a_resv_zero: assert property (
    $rose(hreadyout) && (rd_idx == `TCC_IDX_IRQ_MASK ||
    rd_idx == `TCC_IDX_IRQ_FLAGS)
    |-> hrdata[7:6] == 2'b00 && hrdata[4:3] == 2'b00)
    else $error("reserved mask or flag bits nonzero");
  a_irq_global: assert property (
    (|irq_request) |-> $past(global_irq_enable))
    else $error("request without global enable");
endmodule
bind tcc_timer16 tcc_timer16_chk u_chk (.hclk, .hresetn, .clk_en, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .global_irq_enable, .irq_request);
`default_nettype wire

// ---- tb/tb_tcc_timer16.sv ----
// self-checking bench for the 16-bit timer block
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"
module tb_tcc_timer16 import tcc_pkg::*; ;
  logic hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic capture_pin, comparator_out, external_clock_pin, global_irq_enable;
  tcc_irq_s vector_ack, irq_request;
  logic waveform_out_a, waveform_out_b, waveform_oe_a, waveform_oe_b;
  int fails, num_checks;
  logic [7:0] b;
  logic [15:0] v;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  tcc_timer16 u_dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .capture_pin, .comparator_out, .external_clock_pin, .global_irq_enable,
    .vector_ack, .irq_request, .waveform_out_a, .waveform_out_b,
    .waveform_oe_a, .waveform_oe_b);
  tcc_pin_model u_pins (.hclk, .capture_pin, .comparator_out,
    .external_clock_pin);
  task automatic chk(input string s, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single transfer; waits on ready, no fixed latency assumed
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h00_0000, i, 2'b00};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    b = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic rd(input logic [7:0] i);
    xfer(1'b0, i, 8'h00);
  endtask
  // high byte first on writes, low byte first on reads
  task automatic wr16(input logic [7:0] i, input logic [15:0] d);
    wr(i + 8'h01, d[15:8]);
    wr(i, d[7:0]);
  endtask
  task automatic rd16(input logic [7:0] i);
    rd(i);
    v[7:0] = b;
    rd(i + 8'h01);
    v[15:8] = b;
  endtask
  task automatic t_regs();
    logic [7:0] ix [7];
    ix = '{`TCC_IDX_CAP_CLK_CTRL, `TCC_IDX_FORCE_CTRL, `TCC_IDX_CMPB_LO,
      `TCC_IDX_CMPB_HI, `TCC_IDX_IRQ_MASK, `TCC_IDX_IRQ_FLAGS, 8'h90};
    foreach (ix[k]) begin
      rd(ix[k]);
      chk("reset value", 8'h00, b);
    end
    wr(`TCC_IDX_IRQ_MASK, 8'hff);
    rd(`TCC_IDX_IRQ_MASK);
    chk("mask readback", 8'h27, b);
    wr(8'h90, 8'hff);
    rd(8'h90);
    chk("unmapped", 8'h00, b);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'hd8);
    rd(`TCC_IDX_CAP_CLK_CTRL);
    chk("control readback", 8'hd8, b);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h00);
    done("regs");
  endtask
  // a full write of A between the halves of B shows the shared temp
  task automatic t_word();
    wr(`TCC_IDX_CMPB_HI, 8'h12);
    wr16(`TCC_IDX_CMPA_LO, 16'habcd);
    wr(`TCC_IDX_CMPB_LO, 8'h34);
    rd16(`TCC_IDX_CMPB_LO);
    chk("shared temp write", 16'hab34, v);
    rd(`TCC_IDX_CMPA_LO);
    rd(`TCC_IDX_CMPB_HI);
    chk("shared temp read", 8'hab, b);
    done("word");
  endtask
  // prescaler phase is free, so a count is only known to a window
  task automatic t_clk();
    int n [5];
    int w;
    logic ok;
    n = '{1, 8, 64, 256, 1024};
    foreach (n[k]) begin
      w = 3 * n[k] + 20;
      wr16(`TCC_IDX_CNT_LO, 16'h0000);
      wr(`TCC_IDX_CAP_CLK_CTRL, 8'(k + 1));
      tick(w);
      wr(`TCC_IDX_CAP_CLK_CTRL, 8'h00);
      rd16(`TCC_IDX_CNT_LO);
      ok = v >= w / n[k] && v <= (w + 3) / n[k] + 1;
      chk("prescaled count", 16'h0001, {15'h0000, ok});
    end
    wr16(`TCC_IDX_CNT_LO, 16'h0abc);
    tick(50);
    rd16(`TCC_IDX_CNT_LO);
    chk("stopped count", 16'h0abc, v);
    done("clock select");
  endtask
  // two pulses fall while the block is frozen and must not count
  task automatic t_ext();
    wr16(`TCC_IDX_CNT_LO, 16'h0000);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h07);
    u_pins.pulses(5);
    tick(6);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h06);
    clk_en <= 1'b0;
    u_pins.pulses(2);
    clk_en <= 1'b1;
    u_pins.pulses(3);
    tick(6);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h00);
    rd16(`TCC_IDX_CNT_LO);
    chk("external count", 16'h0008, v);
    done("external clock");
  endtask
  task automatic t_cap();
    wr16(`TCC_IDX_CNT_LO, 16'h1234);
    wr(`TCC_IDX_IRQ_FLAGS, 8'h27);
    u_pins.drive(0, 1'b1, 12);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("rising ignored", 8'h00, b);
    u_pins.drive(0, 1'b0, 12);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("falling flag", 8'h20, b);
    rd16(`TCC_IDX_CAP_LO);
    chk("captured", 16'h1234, v);
    wr(`TCC_IDX_IRQ_FLAGS, 8'h20);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("flag write clear", 8'h00, b);
    wr16(`TCC_IDX_CNT_LO, 16'h4321);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'hc0);
    u_pins.drive(0, 1'b1, 2);
    u_pins.drive(0, 1'b0, 12);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("glitch filtered", 8'h00, b);
    u_pins.drive(0, 1'b1, 12);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("filtered flag", 8'h20, b);
    rd16(`TCC_IDX_CAP_LO);
    chk("filtered capture", 16'h4321, v);
    vector_ack <= 4'b1000;
    tick(1);
    vector_ack <= 4'b0000;
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("vector clear", 8'h00, b);
    wr(`TCC_IDX_AUX_CTRL, 8'h01);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h40);
    u_pins.drive(1, 1'b1, 12);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("comparator source", 8'h20, b);
    wr(`TCC_IDX_AUX_CTRL, 8'h00);
    wr(`TCC_IDX_IRQ_FLAGS, 8'h20);
    done("capture");
  endtask
  task automatic t_cmp();
    wr16(`TCC_IDX_CMPB_LO, 16'h0010);
    wr16(`TCC_IDX_CMPA_LO, 16'h0020);
    wr16(`TCC_IDX_CNT_LO, 16'h0000);
    global_irq_enable <= 1'b1;
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h01);
    tick(60);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h00);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("compare flags", 8'h06, b);
    chk("irq request", 4'b0110, irq_request);
    global_irq_enable <= 1'b0;
    tick(2);
    chk("irq gated", 4'b0000, irq_request);
    global_irq_enable <= 1'b1;
    wr(`TCC_IDX_IRQ_FLAGS, 8'h04);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("b write clear", 8'h02, b);
    vector_ack <= 4'b0010;
    tick(1);
    vector_ack <= 4'b0000;
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("a vector clear", 8'h00, b);
    wr16(`TCC_IDX_CNT_LO, 16'hfffe);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h01);
    tick(8);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h00);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("overflow flag", 8'h01, b);
    wr(`TCC_IDX_IRQ_FLAGS, 8'h27);
    // land the counter right on compare A while it runs
    wr16(`TCC_IDX_CNT_LO, 16'h0100);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h01);
    wr16(`TCC_IDX_CNT_LO, 16'h0020);
    tick(3);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h00);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("match blocked", 8'h00, b);
    done("compare");
  endtask
  // set then clear/toggle, so outcomes do not hang on earlier levels
  task automatic t_force();
    wr(`TCC_IDX_WAVE_CTRL, 8'hf0);
    wr(`TCC_IDX_FORCE_CTRL, 8'hc0);
    tick(2);
    chk("forced set", 2'b11, {waveform_out_a, waveform_out_b});
    wr(`TCC_IDX_WAVE_CTRL, 8'h60);
    wr(`TCC_IDX_FORCE_CTRL, 8'hc0);
    tick(2);
    chk("forced clear", 2'b00, {waveform_out_a, waveform_out_b});
    chk("drivers on", 2'b11, {waveform_oe_a, waveform_oe_b});
    rd(`TCC_IDX_FORCE_CTRL);
    chk("strobes read zero", 8'h00, b);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("no force flags", 8'h00, b);
    chk("no force irq", 4'b0000, irq_request);
    wr16(`TCC_IDX_CNT_LO, 16'h0005);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h08);
    wr(`TCC_IDX_FORCE_CTRL, 8'h80);
    rd16(`TCC_IDX_CNT_LO);
    chk("no force clear", 16'h0005, v);
    done("force");
  endtask
  // capture as top in fast pwm: pin ignored, flag at top
  task automatic t_top();
    wr16(`TCC_IDX_CAP_LO, 16'h0005);
    wr(`TCC_IDX_WAVE_CTRL, 8'h02);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h19);
    wr(`TCC_IDX_FORCE_CTRL, 8'h00);
    u_pins.drive(0, 1'b0, 12);
    wr(`TCC_IDX_CAP_CLK_CTRL, 8'h00);
    rd(`TCC_IDX_IRQ_FLAGS);
    chk("top flags", 8'h21, b);
    rd16(`TCC_IDX_CAP_LO);
    chk("capture off", 16'h0005, v);
    done("top");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // all inputs defined at time zero, reset held six cycles
  initial begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    global_irq_enable = 1'b0;
    vector_ack = 4'b0000;
    fails = 0;
    num_checks = 0;
    tick(6);
    hresetn <= 1'b1;
    tick(1);
    t_regs();
    t_word();
    t_clk();
    t_ext();
    t_cap();
    t_cmp();
    t_force();
    t_top();
    stop_test();
  end
  // run is about 5k cycles; this limit sits far past it
  initial begin
    #400us;
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
